// *** hdl/cct_pkg.sv ***
// constants, field layout and types of the capture/compare timer
// assumes a 16-bit register port with 5-bit word addresses
package cct_pkg;
    localparam int CH_NUM = 4;
    localparam int AW = 5;
    localparam int DW = 16;
    // register word addresses
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_IOSEL = 5'h01;
    localparam logic [4:0] ADDR_FORCE = 5'h02;
    localparam logic [4:0] ADDR_OC7 = 5'h03;
    localparam logic [4:0] ADDR_OUTMODE = 5'h04;
    localparam logic [4:0] ADDR_IRQEN = 5'h05;
    localparam logic [4:0] ADDR_FLAGS = 5'h06;
    localparam logic [4:0] ADDR_PACTL = 5'h07;
    localparam logic [4:0] ADDR_PULSE_FLAG_REG = 5'h08;
    localparam logic [4:0] ADDR_PULSE_COUNT = 5'h09;
    localparam logic [4:0] ADDR_COUNT = 5'h0a;
    localparam logic [4:0] ADDR_PORT = 5'h0b;
    localparam logic [4:0] ADDR_VAL0 = 5'h0c;
    localparam logic [4:0] ADDR_CAPEDGE = 5'h10;
    // control word fields
    localparam int CTRL_PSEL_LSB = 0;
    localparam int CTRL_COUNTER_RESET_ON_CH7 = 3;
    localparam int CTRL_FFC = 4;
    localparam int CTRL_TEN = 5;
    localparam int CTRL_TOIE = 6;
    // pulse control fields
    localparam int PACTL_PEIE = 0;
    localparam int PACTL_OVIE = 1;
    localparam int PACTL_CLK_LSB = 2;
    localparam int PACTL_POL = 4;
    localparam int PACTL_MODE = 5;
    localparam int PACTL_EN = 6;
    // flag positions
    localparam int FLG_TOF = 4;
    localparam int PAF_EDGE = 0;
    localparam int PAF_OVF = 1;
    localparam int OC7_DATA_LSB = 4;
    // reset values
    localparam logic [6:0] RST_CTRL = 7'h00;
    localparam logic [6:0] RST_PACTL = 7'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIB = 4'h0;
    // timing counts
    localparam int PRE_W = 7;
    localparam logic [5:0] DIV64_LAST = 6'h3f;
    localparam logic [7:0] DIV256_LAST = 8'hff;
    localparam logic [15:0] COUNT_LAST = 16'hffff;
    typedef enum logic [1:0] {
        CLK_PRESCALE = 2'h0,
        CLK_PULSE = 2'h1,
        CLK_PULSE256 = 2'h2,
        CLK_PULSE64K = 2'h3
    } cct_clksel_type;
    typedef enum logic [1:0] {
        OUT_OFF = 2'h0,
        OUT_TOGGLE = 2'h1,
        OUT_CLEAR = 2'h2,
        OUT_SET = 2'h3
    } cct_outmode_type;
endpackage

// *** hdl/cct_timer.sv ***
// capture/compare timer with prescaler and pulse accumulator
// assumes channel pins are asynchronous; single bus clock domain
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module cct_timer (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic [3:0] ch_pin_i,
    output logic [3:0] ch_pin_o,
    output logic [3:0] ch_pin_oe_o,
    output logic [3:0] irq_ch_o,
    output logic irq_pulse_edge_o,
    output logic irq_pulse_ovf_o,
    output logic irq_overflow_o
);
    logic [6:0] ctrl_reg;
    logic [3:0] io_select_bit;
    logic [7:0] oc7_reg;
    logic [7:0] outmode_reg;
    logic [3:0] channel_irq_enable;
    logic [3:0] channel_event_flag;
    logic counter_overflow_flag;
    logic [6:0] pactl_reg;
    logic [1:0] pulse_flag_reg;
    logic [15:0] pulse_count;
    logic [15:0] cnt_reg;
    logic cnt_step_reg;
    logic [3:0] port_reg;
    logic [7:0] capedge_reg;
    logic [15:0] channel_value_reg [cct_pkg::CH_NUM];
    logic [3:0] oc_reg;
    logic [cct_pkg::PRE_W-1:0] pre_reg;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] prev_reg;
    logic [15:0] rdata_reg;

    logic timer_on_bit;
    logic [2:0] prescale_select;
    logic counter_reset_on_ch7;
    logic fast_flag_clear;
    logic pulse_en;
    logic accumulate_mode_select;
    logic edge_polarity_select;
    logic [1:0] clk_field;
    logic [7:0] pre_mask;
    logic pre_tick;
    logic div64_tick;
    logic [3:0] rise;
    logic [3:0] fall;
    logic edge7;
    logic gate_active;
    logic pulse_inc;
    logic pulse_wrap;
    logic pulse_clock_source;
    logic cnt_tick;
    logic [3:0] cap;
    logic [3:0] match;
    logic [3:0] force_hit;
    logic ch7_fire;
    logic cnt_clear;
    logic pulse_count_access;
    logic [1:0] pulse_flag_reg_clr;
    logic [1:0] pulse_flag_reg_set;
    logic [15:0] rd_next;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] want);
        hit = (a == want);
    endfunction

    // pin action from the mode/level pair
    function automatic logic out_apply(input logic [1:0] m, input logic q);
        case (m)
            cct_pkg::OUT_TOGGLE: out_apply = ~q;
            cct_pkg::OUT_CLEAR: out_apply = 1'b0;
            cct_pkg::OUT_SET: out_apply = 1'b1;
            default: out_apply = q;
        endcase
    endfunction

    assign prescale_select = ctrl_reg[cct_pkg::CTRL_PSEL_LSB +: 3];
    assign counter_reset_on_ch7 = ctrl_reg[cct_pkg::CTRL_COUNTER_RESET_ON_CH7];
    assign fast_flag_clear = ctrl_reg[cct_pkg::CTRL_FFC];
    assign timer_on_bit = ctrl_reg[cct_pkg::CTRL_TEN];
    assign pulse_en = pactl_reg[cct_pkg::PACTL_EN];
    assign accumulate_mode_select = pactl_reg[cct_pkg::PACTL_MODE];
    assign edge_polarity_select = pactl_reg[cct_pkg::PACTL_POL];
    assign clk_field = pactl_reg[cct_pkg::PACTL_CLK_LSB +: 2];

    // register writes
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= cct_pkg::RST_CTRL;
            io_select_bit <= cct_pkg::RST_NIB;
            oc7_reg <= cct_pkg::RST_BYTE;
            outmode_reg <= cct_pkg::RST_BYTE;
            channel_irq_enable <= cct_pkg::RST_NIB;
            pactl_reg <= cct_pkg::RST_PACTL;
            port_reg <= cct_pkg::RST_NIB;
            capedge_reg <= cct_pkg::RST_BYTE;
        end else if (wr_i) begin
            case (addr_i)
                cct_pkg::ADDR_CTRL: ctrl_reg <= wdata_i[6:0];
                cct_pkg::ADDR_IOSEL: io_select_bit <= wdata_i[3:0];
                cct_pkg::ADDR_OC7: oc7_reg <= wdata_i[7:0];
                cct_pkg::ADDR_OUTMODE: outmode_reg <= wdata_i[7:0];
                cct_pkg::ADDR_IRQEN: channel_irq_enable <= wdata_i[3:0];
                cct_pkg::ADDR_PACTL: pactl_reg <= wdata_i[6:0];
                cct_pkg::ADDR_PORT: port_reg <= wdata_i[3:0];
                cct_pkg::ADDR_CAPEDGE: capedge_reg <= wdata_i[7:0];
                default: ;
            endcase
        end
    end

    // prescaler, held at zero while the timer is off
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !timer_on_bit) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 7'h01;
        end
    end
    assign pre_mask = (8'h01 << prescale_select) - 8'h01;
    assign pre_tick = timer_on_bit && ((pre_reg & pre_mask[6:0]) == pre_mask[6:0]);
    assign div64_tick = timer_on_bit && (pre_reg[5:0] == cct_pkg::DIV64_LAST);

    // pin synchronisers; pulses over two clocks are always seen
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sync1_reg <= cct_pkg::RST_NIB;
            sync2_reg <= cct_pkg::RST_NIB;
            prev_reg <= cct_pkg::RST_NIB;
        end else begin
            sync1_reg <= ch_pin_i;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end
    assign rise = sync2_reg & ~prev_reg;
    assign fall = ~sync2_reg & prev_reg;

    // pulse accumulator on the shared channel 7 pin
    assign edge7 = edge_polarity_select ? rise[3] : fall[3];
    assign gate_active = edge_polarity_select ? ~sync2_reg[3] : sync2_reg[3];
    assign pulse_inc = pulse_en && (accumulate_mode_select ? (gate_active && div64_tick) : edge7);
    assign pulse_wrap = pulse_inc && (pulse_count == cct_pkg::COUNT_LAST);
    assign pulse_count_access = (wr_i || rd_i) && hit(addr_i, cct_pkg::ADDR_PULSE_COUNT);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pulse_count <= cct_pkg::RST_WORD;
        end else if (wr_i && hit(addr_i, cct_pkg::ADDR_PULSE_COUNT)) begin
            pulse_count <= wdata_i;
        end else if (pulse_inc) begin
            pulse_count <= pulse_count + 16'h0001;
        end
    end

    assign pulse_flag_reg_set[cct_pkg::PAF_EDGE] = pulse_en && edge7;
    assign pulse_flag_reg_set[cct_pkg::PAF_OVF] = pulse_wrap;
    assign pulse_flag_reg_clr = ((wr_i && hit(addr_i, cct_pkg::ADDR_PULSE_FLAG_REG)) ? wdata_i[1:0] : 2'h0)
        | ((fast_flag_clear && pulse_count_access) ? 2'h3 : 2'h0);

    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pulse_flag_reg <= 2'h0;
        end else begin
            pulse_flag_reg <= (pulse_flag_reg & ~pulse_flag_reg_clr) | pulse_flag_reg_set;
        end
    end

    // counter clock source
    always_comb begin
        pulse_clock_source = 1'b0;
        case (clk_field)
            cct_pkg::CLK_PULSE: pulse_clock_source = pulse_inc;
            cct_pkg::CLK_PULSE256: pulse_clock_source = pulse_inc && (pulse_count[7:0] == cct_pkg::DIV256_LAST);
            cct_pkg::CLK_PULSE64K: pulse_clock_source = pulse_wrap;
            default: pulse_clock_source = 1'b0;
        endcase
        cnt_tick = timer_on_bit && ((pulse_en && clk_field != cct_pkg::CLK_PRESCALE) ? pulse_clock_source : pre_tick);
    end

    // compare and capture events
    assign ch7_fire = match[3] || force_hit[3];
    assign cnt_clear = match[3] && counter_reset_on_ch7;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= cct_pkg::RST_WORD;
            cnt_step_reg <= 1'b0;
        end else begin
            cnt_step_reg <= cnt_tick && !cnt_clear;
            if (cnt_clear) begin
                cnt_reg <= cct_pkg::RST_WORD;
            end else if (cnt_tick) begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            counter_overflow_flag <= 1'b0;
        end else begin
            counter_overflow_flag <= (counter_overflow_flag
                && !(wr_i && hit(addr_i, cct_pkg::ADDR_FLAGS) && wdata_i[cct_pkg::FLG_TOF]))
                || (cnt_tick && !cnt_clear && cnt_reg == cct_pkg::COUNT_LAST);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < cct_pkg::CH_NUM; gi++) begin : g_ch
            assign cap[gi] = !io_select_bit[gi] && ((capedge_reg[2*gi] && rise[gi])
                || (capedge_reg[2*gi+1] && fall[gi]));
            assign match[gi] = io_select_bit[gi] && cnt_step_reg && (cnt_reg == channel_value_reg[gi]);
            assign force_hit[gi] = wr_i && hit(addr_i, cct_pkg::ADDR_FORCE) && wdata_i[gi] && io_select_bit[gi];

            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    channel_value_reg[gi] <= cct_pkg::RST_WORD;
                end else if (cap[gi]) begin
                    channel_value_reg[gi] <= cnt_reg;
                end else if (wr_i && hit(addr_i, cct_pkg::ADDR_VAL0 + 5'(gi))) begin
                    channel_value_reg[gi] <= wdata_i;
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    oc_reg[gi] <= 1'b0;
                end else if (ch7_fire && oc7_reg[gi]) begin
                    oc_reg[gi] <= oc7_reg[cct_pkg::OC7_DATA_LSB + gi];
                end else if (match[gi] || force_hit[gi]) begin
                    oc_reg[gi] <= out_apply(outmode_reg[2*gi +: 2], oc_reg[gi]);
                end
            end

            // detached pins show the port latch
            assign ch_pin_oe_o[gi] = io_select_bit[gi];
            assign ch_pin_o[gi] = ((outmode_reg[2*gi +: 2] != cct_pkg::OUT_OFF) || oc7_reg[gi])
                ? oc_reg[gi] : port_reg[gi];
        end
    endgenerate

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            channel_event_flag <= cct_pkg::RST_NIB;
        end else begin
            channel_event_flag <= (channel_event_flag
                & ~((wr_i && hit(addr_i, cct_pkg::ADDR_FLAGS)) ? wdata_i[3:0] : 4'h0))
                | cap | match;
        end
    end

    assign irq_ch_o = channel_event_flag & channel_irq_enable;
    assign irq_pulse_edge_o = pulse_flag_reg[cct_pkg::PAF_EDGE] && pactl_reg[cct_pkg::PACTL_PEIE];
    assign irq_pulse_ovf_o = pulse_flag_reg[cct_pkg::PAF_OVF] && pactl_reg[cct_pkg::PACTL_OVIE];
    assign irq_overflow_o = counter_overflow_flag && ctrl_reg[cct_pkg::CTRL_TOIE];

    // read data, valid the cycle after the strobe
    always_comb begin
        rd_next = 16'h0000;
        case (addr_i)
            cct_pkg::ADDR_CTRL: rd_next = {9'h000, ctrl_reg};
            cct_pkg::ADDR_IOSEL: rd_next = {12'h000, io_select_bit};
            cct_pkg::ADDR_OC7: rd_next = {8'h00, oc7_reg};
            cct_pkg::ADDR_OUTMODE: rd_next = {8'h00, outmode_reg};
            cct_pkg::ADDR_IRQEN: rd_next = {12'h000, channel_irq_enable};
            cct_pkg::ADDR_FLAGS: rd_next = {11'h000, counter_overflow_flag, channel_event_flag};
            cct_pkg::ADDR_PACTL: rd_next = {9'h000, pactl_reg};
            cct_pkg::ADDR_PULSE_FLAG_REG: rd_next = {14'h0000, pulse_flag_reg};
            cct_pkg::ADDR_PULSE_COUNT: rd_next = pulse_count;
            cct_pkg::ADDR_COUNT: rd_next = cnt_reg;
            cct_pkg::ADDR_PORT: rd_next = {12'h000, port_reg};
            cct_pkg::ADDR_CAPEDGE: rd_next = {8'h00, capedge_reg};
            5'h0c: rd_next = channel_value_reg[0];
            5'h0d: rd_next = channel_value_reg[1];
            5'h0e: rd_next = channel_value_reg[2];
            5'h0f: rd_next = channel_value_reg[3];
            default: rd_next = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= cct_pkg::RST_WORD;
        end else if (rd_i) begin
            rdata_reg <= rd_next;
        end else begin
            rdata_reg <= cct_pkg::RST_WORD;
        end
    end
    assign rdata_o = rdata_reg;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_cap1;
        cap[1] && !wr_i;
    endsequence

    sequence s_set_match0;
        match[0] && !(ch7_fire && oc7_reg[0]) && outmode_reg[1:0] == cct_pkg::OUT_SET;
    endsequence

    sequence s_clr_match0;
        match[0] && !(ch7_fire && oc7_reg[0]) && outmode_reg[1:0] == cct_pkg::OUT_CLEAR;
    endsequence

    sequence s_fast_access;
        fast_flag_clear && rd_i && hit(addr_i, cct_pkg::ADDR_PULSE_COUNT) && pulse_flag_reg_set == 2'h0;
    endsequence

    AST_PRESCALE: assert property ((pre_tick && prescale_select == 3'h3) |-> pre_reg[2:0] == 3'h7)
        else $error("prescale tick off its divisor");
    AST_CAPTURE: assert property (s_cap1 |=> channel_value_reg[1] == $past(cnt_reg))
        else $error("capture did not copy counter");
    AST_CAPFLAG: assert property (cap[1] |=> channel_event_flag[1])
        else $error("capture flag not set");
    AST_COMPARE_SET: assert property (s_set_match0 |=> oc_reg[0] && channel_event_flag[0])
        else $error("compare set action missing");
    AST_COMPARE_CLR: assert property (s_clr_match0 |=> !oc_reg[0] && channel_event_flag[0])
        else $error("compare clear action missing");
    AST_FORCE: assert property ((force_hit[0] && !match[0] && !cap[0])
        |=> channel_event_flag[0] == $past(channel_event_flag[0]))
        else $error("force changed channel flag");
    AST_OVERRIDE: assert property ((ch7_fire && oc7_reg[0]) |=> oc_reg[0] == $past(oc7_reg[4]))
        else $error("channel 7 override not applied");
    AST_CNT_RESET: assert property (cnt_clear |=> cnt_reg == 16'h0000 ##1 !cnt_clear)
        else $error("counter not reset by channel 7");
    AST_PA_OVF: assert property (pulse_wrap |=> pulse_flag_reg[1] && pulse_count == 16'h0000 || $past(wr_i))
        else $error("pulse overflow flag not set");
    AST_EVENT_CNT: assert property ((pulse_en && !accumulate_mode_select && edge7 && !pulse_count_access)
        |=> pulse_count == $past(pulse_count) + 16'h0001)
        else $error("event edge not counted");
    AST_GATE_STALL: assert property (!timer_on_bit && accumulate_mode_select |-> !pulse_inc)
        else $error("gated count while timer off");
    AST_FAST_CLEAR: assert property (s_fast_access |=> pulse_flag_reg == 2'h0)
        else $error("fast clear did not clear flags");
    AST_DETACH: assert property ((io_select_bit[3] && outmode_reg[7:6] == 2'h0 && !oc7_reg[3])
        |-> ch_pin_o[3] == port_reg[3])
        else $error("detached pin not on port latch");
endmodule

// *** verif/cct_pins_model.sv ***
// far side of the channel pins: external drivers sharing each wire
// assumes the bench supplies the level driven from outside on every pin
`timescale 1ns/10ps
module cct_pins_model (
    input wire logic [3:0] ext_lvl_i,
    input wire logic [3:0] ch_pin_o,
    input wire logic [3:0] ch_pin_oe_o,
    output logic [3:0] ch_pin_i
);
    // device drive wins where enabled, else the outside level
    assign ch_pin_i = (ch_pin_oe_o & ch_pin_o) | (~ch_pin_oe_o & ext_lvl_i);
endmodule

// *** verif/cct_timer_tb.sv ***
// self-checking bench for the capture/compare timer
// assumes the register map and reset values of cct_pkg, single clock
`timescale 1ns/10ps
module cct_timer_tb;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] addr_i = 5'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [3:0] ext_lvl = 4'h0;
    logic [15:0] rdata_o;
    logic [3:0] ch_pin_i, ch_pin_o, ch_pin_oe_o, irq_ch_o;
    logic irq_pulse_edge_o, irq_pulse_ovf_o, irq_overflow_o;
    logic [15:0] v, c0, c1;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;

    cct_timer cct_timer_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ch_pin_i(ch_pin_i), .ch_pin_o(ch_pin_o),
        .ch_pin_oe_o(ch_pin_oe_o), .irq_ch_o(irq_ch_o), .irq_pulse_edge_o(irq_pulse_edge_o),
        .irq_pulse_ovf_o(irq_pulse_ovf_o), .irq_overflow_o(irq_overflow_o));
    cct_pins_model cct_pins_model_inst (.ext_lvl_i(ext_lvl), .ch_pin_o(ch_pin_o),
        .ch_pin_oe_o(ch_pin_oe_o), .ch_pin_i(ch_pin_i));

    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    task automatic complete_run();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 100000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", n, e, g);
            n_mismatch++;
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        @(negedge sys_clk_i);
        d = rdata_o;
    endtask

    task automatic rdc(input logic [4:0] a, input logic [15:0] e, input string n);
        logic [15:0] d;
        rd(a, d);
        chk(n, e, d);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask

    // outside pulses always longer than two clocks
    task automatic pulse(input int ch, input int hi);
        @(posedge sys_clk_i);
        ext_lvl[ch] <= 1'b1;
        repeat (hi) @(posedge sys_clk_i);
        ext_lvl[ch] <= 1'b0;
        tick(6);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rdc(cct_pkg::ADDR_CTRL, 16'h0000, "ctrl");
        rdc(cct_pkg::ADDR_PACTL, 16'h0000, "pactl");
        rdc(5'h1f, 16'h0000, "unmapped");
        chk("irqs", 16'h0000, {9'h000, irq_ch_o, irq_pulse_edge_o, irq_pulse_ovf_o, irq_overflow_o});
        for (int p = 0; p < 8; p++) begin
            wr(cct_pkg::ADDR_CTRL, 16'h0020 | 16'(p));
            rd(cct_pkg::ADDR_COUNT, c0);
            tick(254);
            rd(cct_pkg::ADDR_COUNT, c1);
            chk("prescale", 16'(256 >> p), c1 - c0);
        end
        wr(cct_pkg::ADDR_CTRL, 16'h0000);
        rd(cct_pkg::ADDR_COUNT, c0);
        tick(40);
        rdc(cct_pkg::ADDR_COUNT, c0, "stopped");
        // output compare on channel 4
        wr(cct_pkg::ADDR_CTRL, 16'h0020);
        wr(cct_pkg::ADDR_IOSEL, 16'h0001);
        for (int m = 0; m < 3; m++) begin
            wr(cct_pkg::ADDR_OUTMODE, 16'(3 - m));
            wr(cct_pkg::ADDR_FORCE, 16'h0001);
            tick(3);
            chk("force pin", 16'(m != 1), 16'(ch_pin_o[0]));
        end
        rdc(cct_pkg::ADDR_FLAGS, 16'h0000, "force flag");
        rd(cct_pkg::ADDR_COUNT, c0);
        wr(cct_pkg::ADDR_VAL0, c0 + 16'h0040);
        wr(cct_pkg::ADDR_OUTMODE, 16'h0002);
        tick(80);
        chk("match pin", 16'h0000, {ch_pin_oe_o[0], ch_pin_o[0]} ^ 2'b10);
        rdc(cct_pkg::ADDR_FLAGS, 16'h0001, "match flag");
        chk("irq off", 16'h0000, 16'(irq_ch_o));
        wr(cct_pkg::ADDR_IRQEN, 16'h0001);
        tick(1);
        chk("irq on", 16'h0001, 16'(irq_ch_o));
        wr(cct_pkg::ADDR_PORT, 16'h0001);
        tick(2);
        chk("latched", 16'h0000, 16'(ch_pin_o[0]));
        wr(cct_pkg::ADDR_OUTMODE, 16'h0000);
        tick(2);
        chk("port pin", 16'h0001, 16'(ch_pin_o[0]));
        wr(cct_pkg::ADDR_FLAGS, 16'h0001);
        // input capture on channel 5, rising edges
        wr(cct_pkg::ADDR_CAPEDGE, 16'h0004);
        rd(cct_pkg::ADDR_COUNT, c0);
        pulse(1, 4);
        rd(cct_pkg::ADDR_COUNT, c1);
        rd(cct_pkg::ADDR_VAL0 + 5'h01, v);
        chk("capture", 16'h0001, 16'(v > c0 && v < c1));
        rdc(cct_pkg::ADDR_FLAGS, 16'h0002, "cap flag");
        wr(cct_pkg::ADDR_IRQEN, 16'h0003);
        tick(1);
        chk("cap irq", 16'h0002, 16'(irq_ch_o));
        // channel 7 drives channel 4 and resets the counter
        wr(cct_pkg::ADDR_PORT, 16'h0000);
        wr(cct_pkg::ADDR_IOSEL, 16'h0009);
        wr(cct_pkg::ADDR_OC7, 16'h0011);
        rd(cct_pkg::ADDR_COUNT, c0);
        wr(cct_pkg::ADDR_VAL0 + 5'h03, c0 + 16'h0030);
        wr(cct_pkg::ADDR_CTRL, 16'h0028);
        tick(60);
        chk("ch7 data", 16'h0001, 16'(ch_pin_o[0]));
        rd(cct_pkg::ADDR_COUNT, v);
        chk("ch7 reset", 16'h0001, 16'(v < 16'h0040));
        rdc(cct_pkg::ADDR_FLAGS, 16'h000a, "ch7 flag");
        // free the shared pin, pulse count in event mode, timer off
        wr(cct_pkg::ADDR_CTRL, 16'h0000);
        wr(cct_pkg::ADDR_IOSEL, 16'h0000);
        wr(cct_pkg::ADDR_OC7, 16'h0000);
        wr(cct_pkg::ADDR_PACTL, 16'h0050);
        wr(cct_pkg::ADDR_PULSE_COUNT, 16'hfffe);
        pulse(3, 4);
        pulse(3, 4);
        rdc(cct_pkg::ADDR_PULSE_COUNT, 16'h0000, "pulse_count");
        rdc(cct_pkg::ADDR_PULSE_FLAG_REG, 16'h0003, "pulse_flag_reg");
        chk("ovf irq off", 16'h0000, 16'(irq_pulse_ovf_o));
        wr(cct_pkg::ADDR_PACTL, 16'h0052);
        tick(1);
        chk("ovf irq on", 16'h0001, 16'(irq_pulse_ovf_o));
        wr(cct_pkg::ADDR_PULSE_FLAG_REG, 16'h0002);
        rdc(cct_pkg::ADDR_PULSE_FLAG_REG, 16'h0001, "w1c");
        wr(cct_pkg::ADDR_CTRL, 16'h0010);
        rd(cct_pkg::ADDR_PULSE_COUNT, v);
        rdc(cct_pkg::ADDR_PULSE_FLAG_REG, 16'h0000, "fast clear");
        // counter clocked by pulse clock source
        wr(cct_pkg::ADDR_CTRL, 16'h0020);
        wr(cct_pkg::ADDR_PACTL, 16'h0054);
        rd(cct_pkg::ADDR_COUNT, c0);
        pulse(3, 4);
        pulse(3, 4);
        rd(cct_pkg::ADDR_COUNT, c1);
        chk("pulse clock", 16'h0002, c1 - c0);
        // gated accumulation, high level active
        wr(cct_pkg::ADDR_PACTL, 16'h0061);
        wr(cct_pkg::ADDR_PULSE_COUNT, 16'h0000);
        wr(cct_pkg::ADDR_PULSE_FLAG_REG, 16'h0003);
        pulse(3, 640);
        rd(cct_pkg::ADDR_PULSE_COUNT, v);
        chk("gated", 16'h0001, 16'(v >= 16'h0009 && v <= 16'h000b));
        rdc(cct_pkg::ADDR_PULSE_FLAG_REG, 16'h0001, "gate edge");
        chk("edge irq", 16'h0001, 16'(irq_pulse_edge_o));
        wr(cct_pkg::ADDR_CTRL, 16'h0000);
        wr(cct_pkg::ADDR_PULSE_COUNT, 16'h0000);
        pulse(3, 640);
        rdc(cct_pkg::ADDR_PULSE_COUNT, 16'h0000, "gate stall");
        // counter wrap
        wr(cct_pkg::ADDR_PACTL, 16'h0000);
        wr(cct_pkg::ADDR_FLAGS, 16'h001f);
        wr(cct_pkg::ADDR_CTRL, 16'h0060);
        tick(65600);
        rdc(cct_pkg::ADDR_FLAGS, 16'h0010, "wrap flag");
        chk("wrap irq", 16'h0001, 16'(irq_overflow_o));
        complete_run();
    end
endmodule
